/* core/udtec_top.sv */
// APB slave, 11-bit up/down counter and two edge sense channels
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module udtec_top #(
    parameter int PINS = udtec_pkg::PINS,
    parameter int CNT_W = udtec_pkg::CNT_W,
    parameter int RTC_W = udtec_pkg::RTC_W,
    parameter int PER_W = udtec_pkg::PER_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [udtec_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [PINS-1:0] gpio_in,
    input wire logic low_power_clock,
    input wire logic [RTC_W-1:0] rtc_value,
    output logic counter_irq,
    output logic ch1_irq,
    output logic ch2_irq
);
    // Field packing depends on these limits
    if (CNT_W > 16 || CNT_W < 2 || RTC_W > 32 || RTC_W <= CNT_W) begin : g_bad_width
        $error("udtec_top: unsupported counter or snapshot width");
    end
    if (PINS < 1 || PINS > 15 || PER_W > 8 || PER_W < 2) begin : g_bad_chan
        $error("udtec_top: unsupported pin count or period width");
    end

    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic [31:0] ctrl_r;
    logic [31:0] cfg_r;
    logic [PINS-1:0] gpio_s1_r;
    logic [PINS-1:0] gpio_s2_r;
    logic lpc_s1_r;
    logic lpc_s2_r;
    logic lpc_d_r;
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic tmr_ev_r;
    logic counter_irq_r;

    // APB decode
    wire acc_wait = psel & penable & ~pready_r;
    wire acc_done = psel & penable & pready_r;
    wire wr_done = acc_done & pwrite;
    wire sel_ctrl = (paddr == udtec_pkg::OFS_CTRL);
    wire sel_cfg = (paddr == udtec_pkg::OFS_CFG);
    wire sel_stat = (paddr == udtec_pkg::OFS_STAT);
    wire sel_clr = (paddr == udtec_pkg::OFS_CLR);
    wire sel_cap1 = (paddr == udtec_pkg::OFS_CAP1);
    wire sel_cap2 = (paddr == udtec_pkg::OFS_CAP2);
    wire mapped = sel_ctrl | sel_cfg | sel_stat | sel_clr | sel_cap1 | sel_cap2;
    wire clr_wr = wr_done & sel_clr;
    wire clr_ch1 = clr_wr & pwdata[udtec_pkg::CLR_CH1];
    wire clr_ch2 = clr_wr & pwdata[udtec_pkg::CLR_CH2];
    wire clr_tmr = clr_wr & pwdata[udtec_pkg::CLR_TMR];

    // Control fields
    wire run = ctrl_r[udtec_pkg::CTRL_RUN];
    wire gate = ctrl_r[udtec_pkg::CTRL_GATE];
    wire irq_on = ctrl_r[udtec_pkg::CTRL_IRQ];
    wire down = ctrl_r[udtec_pkg::CTRL_DOWN];
    wire wrap_on = ctrl_r[udtec_pkg::CTRL_WRAP];
    wire fast = ctrl_r[udtec_pkg::CTRL_FAST];
    wire [CNT_W-1:0] reload = ctrl_r[udtec_pkg::CTRL_RELOAD_LSB +: CNT_W];
    wire [31:0] ctrl_mask = udtec_pkg::CTRL_MASK;

    // Low-power clock becomes a one-cycle tick on its rising edge
    wire lpc_rise = lpc_s2_r & ~lpc_d_r;
    wire tick = fast ? 1'b1 : lpc_rise;
    wire step = run & gate & tick;
    // Wraparound is honoured only while counting up
    wire wrap = wrap_on & ~down;
    wire [CNT_W-1:0] cnt_inc = count_r + {{(CNT_W-1){1'b0}}, 1'b1};
    wire [CNT_W-1:0] cnt_dec = count_r - {{(CNT_W-1){1'b0}}, 1'b1};
    wire hit_down = (count_r == '0);
    wire hit_wrap = (cnt_inc == '0);
    wire hit_up = (count_r == reload);
    wire hit = down ? hit_down : (wrap ? hit_wrap : hit_up);
    wire tmr_set = step & hit;

    udtec_ch_if #(.PINS(PINS), .CNT_W(CNT_W), .RTC_W(RTC_W), .PER_W(PER_W)) ch1_if ();
    udtec_ch_if #(.PINS(PINS), .CNT_W(CNT_W), .RTC_W(RTC_W), .PER_W(PER_W)) ch2_if ();

    // Channel configuration and shared stimulus; both may pick the same pin
    localparam int C2 = udtec_pkg::CFG_CH2;
    assign ch1_if.pin_sel = cfg_r[udtec_pkg::CFG_SEL_LSB +: udtec_pkg::SEL_W];
    assign ch1_if.falling = cfg_r[udtec_pkg::CFG_FALL];
    assign ch1_if.counting = cfg_r[udtec_pkg::CFG_COUNT];
    assign ch1_if.irq_on = cfg_r[udtec_pkg::CFG_IRQ];
    assign ch1_if.src_rtc = cfg_r[udtec_pkg::CFG_SRC];
    assign ch1_if.period = cfg_r[udtec_pkg::CFG_PER_LSB +: PER_W];
    assign ch1_if.pins = gpio_s2_r;
    assign ch1_if.tick = step;
    assign ch1_if.run = run;
    assign ch1_if.clear = clr_ch1;
    assign ch1_if.count = count_r;
    assign ch1_if.rtc = rtc_value;
    assign ch2_if.pin_sel = cfg_r[C2 + udtec_pkg::CFG_SEL_LSB +: udtec_pkg::SEL_W];
    assign ch2_if.falling = cfg_r[C2 + udtec_pkg::CFG_FALL];
    assign ch2_if.counting = cfg_r[C2 + udtec_pkg::CFG_COUNT];
    assign ch2_if.irq_on = cfg_r[C2 + udtec_pkg::CFG_IRQ];
    assign ch2_if.src_rtc = cfg_r[C2 + udtec_pkg::CFG_SRC];
    assign ch2_if.period = cfg_r[C2 + udtec_pkg::CFG_PER_LSB +: PER_W];
    assign ch2_if.pins = gpio_s2_r;
    assign ch2_if.tick = step;
    assign ch2_if.run = run;
    assign ch2_if.clear = clr_ch2;
    assign ch2_if.count = count_r;
    assign ch2_if.rtc = rtc_value;

    udtec_channel #(.PINS(PINS), .CNT_W(CNT_W), .RTC_W(RTC_W), .PER_W(PER_W)) u_ch1 (
        .pclk(pclk),
        .presetn(presetn),
        .chi(ch1_if.ch)
    );

    udtec_channel #(.PINS(PINS), .CNT_W(CNT_W), .RTC_W(RTC_W), .PER_W(PER_W)) u_ch2 (
        .pclk(pclk),
        .presetn(presetn),
        .chi(ch2_if.ch)
    );

    // Status word and read mux
    wire [1:0] ev_bits = {ch2_if.event_flag, ch1_if.event_flag};
    wire [1:0] lost_bits = {ch2_if.lost, ch1_if.lost};
    wire [31:0] stat_word = (32'(count_r) << udtec_pkg::ST_CNT_LSB)
                          | (32'(tmr_ev_r) << udtec_pkg::ST_TMR)
                          | (32'(lost_bits) << udtec_pkg::ST_LOST_LSB)
                          | (32'(ev_bits) << udtec_pkg::ST_EV_LSB);
    wire [31:0] rdata = sel_ctrl ? ctrl_r
                      : sel_cfg ? cfg_r
                      : sel_stat ? stat_word
                      : sel_cap1 ? 32'(ch1_if.value)
                      : sel_cap2 ? 32'(ch2_if.value)
                      : 32'h0000_0000;

    // Every access has one wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= acc_wait;
            pslverr_r <= acc_wait & ~mapped;
            if (acc_wait) begin
                prdata_r <= pwrite ? 32'h0000_0000 : rdata;
            end
        end
    end

    // Software registers; only presetn clears them, so they ride out system power-down
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= udtec_pkg::CTRL_RST;
            cfg_r <= udtec_pkg::CFG_RST;
        end else begin
            if (wr_done & sel_ctrl) begin
                ctrl_r <= pwdata & ctrl_mask;
            end
            if (wr_done & sel_cfg) begin
                cfg_r <= pwdata;
            end
        end
    end

    // Two-stage synchronisers for pins and the low-power clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpio_s1_r <= '0;
            gpio_s2_r <= '0;
            lpc_s1_r <= 1'b0;
            lpc_s2_r <= 1'b0;
            lpc_d_r <= 1'b0;
        end else begin
            gpio_s1_r <= gpio_in;
            gpio_s2_r <= gpio_s1_r;
            lpc_s1_r <= low_power_clock;
            lpc_s2_r <= lpc_s1_r;
            lpc_d_r <= lpc_s2_r;
        end
    end

    // Counter next value: down reloads at zero, up restarts after threshold, wrap rolls over
    always_comb begin
        count_nxt = count_r;
        if (!run) begin
            count_nxt = '0;
        end else if (step) begin
            if (down) begin
                count_nxt = hit_down ? reload : cnt_dec;
            end else if (wrap) begin
                count_nxt = cnt_inc;
            end else begin
                count_nxt = hit_up ? '0 : cnt_inc;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= '0;
            tmr_ev_r <= 1'b0;
            counter_irq_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            tmr_ev_r <= (tmr_ev_r & ~clr_tmr) | tmr_set;
            counter_irq_r <= tmr_ev_r & irq_on;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign counter_irq = counter_irq_r;
    assign ch1_irq = ch1_if.irq;
    assign ch2_irq = ch2_if.irq;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_acc_wait;
        psel && penable && !pready_r;
    endsequence
    sequence s_ready_once;
        pready_r ##1 !pready_r;
    endsequence

    apb_ready_a: assert property (s_acc_wait |=> s_ready_once)
        else $error("apb ready not one cycle after access");
    tmr_wrap_a: assert property (step && wrap && count_r == {CNT_W{1'b1}} |=> tmr_ev_r && count_r == 0)
        else $error("wrap through zero not flagged");
    tmr_reload_a: assert property (step && !down && !wrap && count_r == reload |=> tmr_ev_r && count_r == 0)
        else $error("threshold not flagged");
    tmr_down_a: assert property (step && down && count_r != 0 |=> count_r == $past(count_r) - 1'b1)
        else $error("down count step wrong");
    tmr_gate_a: assert property (run && !gate |=> count_r == $past(count_r))
        else $error("counter moved with clock gate off");
    tmr_irq_a: assert property (tmr_ev_r && irq_on |=> counter_irq_r)
        else $error("counter interrupt missing");
    apb_err_a: assert property (s_acc_wait && !mapped |=> pslverr_r && prdata_r == 0)
        else $error("unmapped access not refused");
    ctrl_write_a: assert property (wr_done && sel_ctrl |=> ctrl_r == ($past(pwdata) & ctrl_mask))
        else $error("control write not masked");
    tmr_stop_a: assert property (!run |=> count_r == 0)
        else $error("stopped counter not cleared");
    tmr_up_a: assert property (step && !down && !wrap && !hit_up |=> count_r == $past(count_r) + 1'b1)
        else $error("up count step wrong");
    tmr_hold_a: assert property (tmr_ev_r && !clr_tmr |=> tmr_ev_r)
        else $error("timer flag dropped without clear");
    tmr_clear_a: assert property (clr_tmr && !tmr_set |=> !tmr_ev_r)
        else $error("timer flag not cleared");
endmodule

/* core/udtec_pkg.sv */
// Constants, register map and field layout of the up/down timer with edge capture
package udtec_pkg;
    localparam int CNT_W = 11;
    localparam int RTC_W = 22;
    localparam int PINS = 12;
    localparam int PER_W = 8;
    localparam int SEL_W = 4;
    localparam int ADDR_W = 8;
    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CFG = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CLR = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_CAP1 = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_CAP2 = 8'h14;
    // Counter control fields
    localparam int CTRL_RUN = 0;
    localparam int CTRL_GATE = 1;
    localparam int CTRL_IRQ = 2;
    localparam int CTRL_DOWN = 3;
    localparam int CTRL_WRAP = 4;
    localparam int CTRL_FAST = 5;
    localparam int CTRL_RELOAD_LSB = 16;
    localparam logic [31:0] CTRL_MASK = 32'h07ff_003f;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    // Sense config fields, channel 2 sits CFG_CH2 bits higher
    localparam int CFG_SEL_LSB = 0;
    localparam int CFG_FALL = 4;
    localparam int CFG_COUNT = 5;
    localparam int CFG_IRQ = 6;
    localparam int CFG_SRC = 7;
    localparam int CFG_PER_LSB = 8;
    localparam int CFG_CH2 = 16;
    localparam logic [31:0] CFG_RST = 32'h0000_0000;
    // Status and clear fields
    localparam int ST_EV_LSB = 0;
    localparam int ST_LOST_LSB = 2;
    localparam int ST_TMR = 4;
    localparam int ST_CNT_LSB = 16;
    localparam int CLR_CH1 = 0;
    localparam int CLR_CH2 = 1;
    localparam int CLR_TMR = 2;
    localparam logic [SEL_W-1:0] SEL_FIRST = 4'h1;
endpackage

/* core/udtec_ch_if.sv */
// Configuration and result bundle between the timer core and one sense channel
`timescale 1ns/1ps
interface udtec_ch_if #(
    parameter int PINS = 12,
    parameter int CNT_W = 11,
    parameter int RTC_W = 22,
    parameter int PER_W = 8
);
    logic [udtec_pkg::SEL_W-1:0] pin_sel;
    logic falling;
    logic counting;
    logic irq_on;
    logic src_rtc;
    logic [PER_W-1:0] period;
    logic [PINS-1:0] pins;
    logic tick;
    logic run;
    logic clear;
    logic [CNT_W-1:0] count;
    logic [RTC_W-1:0] rtc;
    logic event_flag;
    logic lost;
    logic irq;
    logic [RTC_W-1:0] value;
    modport top (output pin_sel, falling, counting, irq_on, src_rtc, period, pins, tick, run,
                 clear, count, rtc, input event_flag, lost, irq, value);
    modport ch (input pin_sel, falling, counting, irq_on, src_rtc, period, pins, tick, run,
                clear, count, rtc, output event_flag, lost, irq, value);
endinterface

/* core/udtec_channel.sv */
// One edge sense channel: capture or edge-group cycle counting
`timescale 1ns/1ps
module udtec_channel #(
    parameter int PINS = 12,
    parameter int CNT_W = 11,
    parameter int RTC_W = 22,
    parameter int PER_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    udtec_ch_if.ch chi
);
    logic lvl_d_r;
    logic ev_r;
    logic lost_r;
    logic irq_r;
    logic [RTC_W-1:0] value_r;
    logic [PER_W-1:0] edge_cnt_r;
    logic [RTC_W-1:0] cyc_r;

    wire sel_ok = (chi.pin_sel >= udtec_pkg::SEL_FIRST) && (chi.pin_sel <= PINS);
    wire [udtec_pkg::SEL_W-1:0] idx = chi.pin_sel - udtec_pkg::SEL_FIRST;
    wire pin_lvl = sel_ok ? chi.pins[idx] : 1'b0;
    wire edg = chi.falling ? (lvl_d_r & ~pin_lvl) : (~lvl_d_r & pin_lvl);
    wire cnt_mode = chi.counting & chi.run;
    wire [PER_W:0] seen = {1'b0, edge_cnt_r} + {{PER_W{1'b0}}, 1'b1};
    wire grp_done = cnt_mode & edg & (seen >= {1'b0, chi.period});
    wire cap_ev = chi.counting ? grp_done : edg;
    wire [RTC_W-1:0] cyc_now = cyc_r + {{(RTC_W-1){1'b0}}, chi.tick};
    wire [RTC_W-1:0] stamp = chi.src_rtc ? chi.rtc : {{(RTC_W-CNT_W){1'b0}}, chi.count};
    wire [RTC_W-1:0] snap = chi.counting ? cyc_now : stamp;
    wire store = cap_ev & (~ev_r | chi.clear);
    wire ev_nxt = (ev_r & ~chi.clear) | cap_ev;
    wire lost_nxt = (lost_r & ~chi.clear) | (cap_ev & ev_r & ~chi.clear);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_d_r <= 1'b0;
            ev_r <= 1'b0;
            lost_r <= 1'b0;
            irq_r <= 1'b0;
            value_r <= '0;
        end else begin
            lvl_d_r <= pin_lvl;
            ev_r <= ev_nxt;
            lost_r <= lost_nxt;
            irq_r <= ev_nxt & chi.irq_on;
            if (store) begin
                value_r <= snap;
            end
        end
    end

    // Edge group counter; the closing edge opens the next group
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_cnt_r <= '0;
            cyc_r <= '0;
        end else if (!cnt_mode) begin
            edge_cnt_r <= '0;
            cyc_r <= '0;
        end else if (grp_done) begin
            edge_cnt_r <= {{(PER_W-1){1'b0}}, 1'b1};
            cyc_r <= '0;
        end else begin
            if (edg) begin
                edge_cnt_r <= seen[PER_W-1:0];
            end
            if (edge_cnt_r != '0) begin
                cyc_r <= cyc_now;
            end
        end
    end

    assign chi.event_flag = ev_r;
    assign chi.lost = lost_r;
    assign chi.irq = irq_r;
    assign chi.value = value_r;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ch_store_a: assert property (cap_ev && !ev_r |=> ev_r && value_r == $past(snap))
        else $error("channel snapshot not stored");
    ch_keep_a: assert property (cap_ev && ev_r && !chi.clear |=> lost_r && value_r == $past(value_r))
        else $error("pending snapshot overwritten");
    ch_clear_a: assert property (chi.clear && !cap_ev |=> !ev_r && !lost_r)
        else $error("event or lost flag not cleared");
    ch_irq_a: assert property (##1 irq_r == (ev_r && $past(chi.irq_on)))
        else $error("channel interrupt mismatch");
    ch_restart_a: assert property (grp_done |=> edge_cnt_r == 1 && cyc_r == 0)
        else $error("edge group did not restart");
endmodule

/* tb/udtec_far_model.sv */
// Far side model: pin edge sources, RTC port value and the slow clock
`timescale 1ns/1ps
module udtec_far_model #(
    parameter int PINS = 12,
    parameter int RTC_W = 22,
    parameter int LP_HALF = 8
) (
    input wire logic pclk,
    output logic [PINS-1:0] gpio_in,
    output logic [RTC_W-1:0] rtc_value,
    output logic low_power_clock
);
    int lp_cnt = 0;

    initial begin
        gpio_in = '0;
        rtc_value = '0;
        low_power_clock = 1'b0;
    end

    // Slow clock runs free, period 2*LP_HALF pclk cycles
    always @(posedge pclk) begin
        lp_cnt <= (lp_cnt == LP_HALF - 1) ? 0 : lp_cnt + 1;
        if (lp_cnt == LP_HALF - 1) begin
            low_power_clock <= ~low_power_clock;
        end
    end

    // RTC port is synchronous to pclk
    task automatic set_rtc(input logic [RTC_W-1:0] v);
        @(posedge pclk);
        rtc_value <= v;
    endtask

    task automatic set_pin(input int pin, input logic v);
        @(posedge pclk);
        gpio_in[pin] <= v;
    endtask

    // Rising edges spaced exactly 2*half cycles apart
    task automatic pulse_train(input int pin, input int n, input int half);
        repeat (n) begin
            @(posedge pclk);
            gpio_in[pin] <= 1'b1;
            repeat (half) @(posedge pclk);
            gpio_in[pin] <= 1'b0;
            repeat (half - 1) @(posedge pclk);
        end
    endtask
endmodule

/* tb/udtec_tb.sv */
// Register level test of the up/down timer with edge capture
`timescale 1ns/1ps
module udtec_tb;
    localparam int PER = 3;
    localparam int HALF = 10;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [udtec_pkg::ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [udtec_pkg::PINS-1:0] gpio_in;
    logic low_power_clock;
    logic [udtec_pkg::RTC_W-1:0] rtc_value;
    logic counter_irq;
    logic ch1_irq;
    logic ch2_irq;
    logic [31:0] rd;
    logic [31:0] held;
    logic err;
    int cyc;
    int num_errors = 0;
    int samples_checked = 0;

    always #10 pclk = ~pclk;

    udtec_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .gpio_in(gpio_in), .low_power_clock(low_power_clock),
        .rtc_value(rtc_value), .counter_irq(counter_irq), .ch1_irq(ch1_irq),
        .ch2_irq(ch2_irq));

    udtec_far_model far (.pclk(pclk), .gpio_in(gpio_in), .rtc_value(rtc_value),
        .low_power_clock(low_power_clock));

    task automatic close_out();
        $display("Checks %0d, errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic chk1(input string what, input logic seen, input logic exp);
        chk(what, {31'h0, seen}, {31'h0, exp});
    endtask

    // Setup, then access held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        chk1("pready", pready, 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(what, rd & m, exp);
    endtask

    task automatic wait_irq(input int which, input int lim);
        logic s;
        cyc = 0;
        s = 1'b0;
        while (s !== 1'b1 && cyc < lim) begin
            @(posedge pclk);
            cyc++;
            s = (which == 0) ? counter_irq : (which == 1) ? ch1_irq : ch2_irq;
        end
    endtask

    task automatic cnt_bound(input int lim);
        repeat (3) begin
            apb(1'b0, udtec_pkg::OFS_STAT, 32'h0000_0000);
            chk1("count bound", rd[26:16] <= lim, 1'b1);
        end
    endtask

    // Stop the counter and drop its flag
    task automatic stop_timer();
        apb(1'b1, udtec_pkg::OFS_CTRL, 32'h0000_0000);
        apb(1'b1, udtec_pkg::OFS_CLR, 32'h0000_0004);
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdc("ctrl reset", udtec_pkg::OFS_CTRL, 32'hffff_ffff, 32'h0000_0000);
        rdc("cfg reset", udtec_pkg::OFS_CFG, 32'hffff_ffff, 32'h0000_0000);
        rdc("stat reset", udtec_pkg::OFS_STAT, 32'hffff_ffff, 32'h0000_0000);
        apb(1'b0, 8'h18, 32'h0000_0000);
        chk1("unmapped err", err, 1'b1);
        chk("unmapped data", rd, 32'h0000_0000);
        apb(1'b1, udtec_pkg::OFS_CTRL, 32'hffff_ffc0);
        rdc("ctrl fields", udtec_pkg::OFS_CTRL, 32'hffff_ffff, 32'h07ff_0000);
        // Up count to reload 5 on the fast tick
        apb(1'b1, udtec_pkg::OFS_CTRL, 32'h0005_0027);
        wait_irq(0, 40);
        chk1("fast tick flag", cyc <= 12, 1'b1);
        cnt_bound(5);
        stop_timer();
        rdc("timer flag clr", udtec_pkg::OFS_STAT, 32'h0000_0010, 32'h0000_0000);
        chk1("timer irq clr", counter_irq, 1'b0);
        // Up count to reload 2 on the slow tick
        apb(1'b1, udtec_pkg::OFS_CTRL, 32'h0002_0007);
        wait_irq(0, 200);
        chk1("slow tick flag", cyc >= 14 && cyc <= 90, 1'b1);
        stop_timer();
        // Down count flags at its floor and reloads 3
        apb(1'b1, udtec_pkg::OFS_CTRL, 32'h0003_002f);
        wait_irq(0, 20);
        chk1("down flag", counter_irq, 1'b1);
        cnt_bound(3);
        stop_timer();
        // Wraparound, counting up only
        apb(1'b1, udtec_pkg::OFS_CTRL, 32'h07ff_0037);
        wait_irq(0, 2100);
        chk1("wrap period", cyc >= 2035 && cyc <= 2060, 1'b1);
        stop_timer();
        // Fast tick running, then gate off: count must freeze where it stands
        apb(1'b1, udtec_pkg::OFS_CTRL, 32'h07ff_0023);
        apb(1'b1, udtec_pkg::OFS_CTRL, 32'h07ff_0021);
        apb(1'b0, udtec_pkg::OFS_STAT, 32'h0000_0000);
        held = rd & 32'h07ff_0000;
        chk1("count moved", held != 0, 1'b1);
        repeat (2) rdc("gated count", udtec_pkg::OFS_STAT, 32'h07ff_0000, held);
        // Ch1 rising RTC capture, ch2 falling on the same pin, masked
        far.set_rtc(22'h2a_5a5a);
        apb(1'b1, udtec_pkg::OFS_CFG, 32'h0011_00c1);
        far.set_pin(0, 1'b1);
        repeat (6) @(posedge pclk);
        rdc("rise only", udtec_pkg::OFS_STAT, 32'h0000_000f, 32'h0000_0001);
        far.set_pin(0, 1'b0);
        repeat (6) @(posedge pclk);
        rdc("both events", udtec_pkg::OFS_STAT, 32'h0000_000f, 32'h0000_0003);
        rdc("rtc snapshot", udtec_pkg::OFS_CAP1, 32'hffff_ffff, 32'h002a_5a5a);
        rdc("count snapshot", udtec_pkg::OFS_CAP2, 32'hffff_ffff, held >> 16);
        chk1("ch1 irq", ch1_irq, 1'b1);
        chk1("ch2 masked", ch2_irq, 1'b0);
        far.set_rtc(22'h15_a5a5);
        far.set_pin(0, 1'b1);
        repeat (6) @(posedge pclk);
        rdc("snapshot kept", udtec_pkg::OFS_CAP1, 32'hffff_ffff, 32'h002a_5a5a);
        rdc("ch1 lost", udtec_pkg::OFS_STAT, 32'h0000_000f, 32'h0000_0007);
        apb(1'b1, udtec_pkg::OFS_CLR, 32'h0000_0001);
        rdc("ch1 cleared", udtec_pkg::OFS_STAT, 32'h0000_000f, 32'h0000_0002);
        chk1("ch1 irq clr", ch1_irq, 1'b0);
        apb(1'b1, udtec_pkg::OFS_CLR, 32'h0000_0002);
        // Counting mode on pin 1 over repeated edge groups
        apb(1'b1, udtec_pkg::OFS_CTRL, 32'h07ff_0037);
        apb(1'b1, udtec_pkg::OFS_CFG, 32'h0000_0062 | (PER << 8));
        fork
            far.pulse_train(1, 2 * PER - 1, HALF);
        join_none
        wait_irq(1, 200);
        chk1("group irq", ch1_irq, 1'b1);
        rdc("group cycles", udtec_pkg::OFS_CAP1, 32'hffff_ffff, (PER - 1) * 2 * HALF);
        apb(1'b1, udtec_pkg::OFS_CLR, 32'h0000_0001);
        wait_irq(1, 200);
        rdc("next group", udtec_pkg::OFS_CAP1, 32'hffff_ffff, (PER - 1) * 2 * HALF);
        rdc("no loss", udtec_pkg::OFS_STAT, 32'h0000_0005, 32'h0000_0001);
        close_out();
    end

    // Whole sequence needs under 10000 cycles
    initial begin
        #(400_000);
        num_errors++;
        close_out();
    end
endmodule
